//--- rtl/eab_regs.vh
// Summary of operation
// - write data, strobe, address follow write clock
// - fetch strobe, address, output follow read clock
// - each side has own enable and clear
// - registers cleared by local, global or reset
// - two shared clears from global and local
// - macrocell picks clear one, two or none
// - each shared clear may be inverted
// - OR takes own two plus thirty lent
// - at most fifteen sets of two terms
`ifndef EAB_REGS_VH
`define EAB_REGS_VH
`define EAB_SEL_NONE   2'h0
`define EAB_SEL_ONE    2'h1
`define EAB_SEL_TWO    2'h2
`define EAB_OWN_TERMS  2
`define EAB_MAX_SETS   15
`define EAB_SET_BITS   4
`define EAB_CLR_W      2
`define EAB_SEL_W      2
`endif

//--- rtl/eab_block.v
`timescale 1ns/1ps
`default_nettype none
`include "eab_regs.vh"
module eab_block #(
  parameter AW = 4,
  parameter DW = 8,
  parameter NMC = 16
) (
  // clock and reset
  input  wire                        ref_clk,
  input  wire                        rst_b,
  // clears shared by the memory side
  input  wire                        glob_clear,
  // write side
  input  wire                        wr_clk,
  input  wire                        clock_gate_one,
  input  wire                        wr_clear,
  input  wire                        wr_strobe,
  input  wire [AW-1:0]               wr_addr,
  input  wire [DW-1:0]               wr_data,
  // read side
  input  wire                        rd_clk,
  input  wire                        clock_gate_two,
  input  wire                        rd_clear,
  input  wire                        fetch_strobe,
  input  wire [AW-1:0]               rd_addr,
  output reg  [DW-1:0]               rd_data_r,
  // product-term mode
  input  wire [`EAB_CLR_W-1:0]       pt_glob_clr,
  input  wire [`EAB_CLR_W-1:0]       pt_loc_clr,
  input  wire [`EAB_CLR_W-1:0]       pt_clr_inv,
  input  wire [`EAB_SEL_W*NMC-1:0]   pt_clr_sel,
  input  wire [`EAB_SET_BITS*NMC-1:0] pt_exp_sets,
  input  wire [`EAB_OWN_TERMS*NMC-1:0] pt_terms,
  output reg  [NMC-1:0]              mc_out_r
);
  // reset synchroniser
  reg                        rst_s1_r;
  reg                        rst_s2_r;
  wire                       rst_n;

  // side clock edges
  reg                        wr_clk_d_r;
  reg                        rd_clk_d_r;
  wire                       wr_edge;
  wire                       rd_edge;
  wire                       wr_take;
  wire                       rd_take;

  // write group
  wire                       wr_clr;
  reg                        wstb_r;
  reg                        wstb_nxt;
  reg  [AW-1:0]              waddr_r;
  reg  [AW-1:0]              waddr_nxt;
  reg  [DW-1:0]              wdata_r;
  reg  [DW-1:0]              wdata_nxt;

  // read group
  wire                       rd_clr;
  reg                        fetch_r;
  reg                        fetch_nxt;
  reg  [AW-1:0]              raddr_r;
  reg  [AW-1:0]              raddr_nxt;

  // storage array
  reg  [DW-1:0]              mem [0:(1<<AW)-1];

  // product-term side
  wire [`EAB_CLR_W-1:0]      shared_src;
  wire [`EAB_CLR_W-1:0]      shared_clr;
  wire                       shared_clear_one;
  wire                       shared_clear_two;
  wire [NMC-1:0]             mc_or;
  wire [NMC-1:0]             mc_clr;
  wire [NMC-1:0]             mc_nxt;

  // reset is entered asynchronously but is released on the clock
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // side clocks arrive as sampled levels; their rising edges act as the clocks
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_clk_d_r <= 1'b0;
      rd_clk_d_r <= 1'b0;
    end else begin
      wr_clk_d_r <= wr_clk;
      rd_clk_d_r <= rd_clk;
    end
  end
  assign wr_edge = wr_clk & ~wr_clk_d_r;
  assign rd_edge = rd_clk & ~rd_clk_d_r;
  assign wr_take = wr_edge & clock_gate_one;
  assign rd_take = rd_edge & clock_gate_two;

  // write group: touched only by the write clock, its gate, its clear and the global clear
  assign wr_clr = wr_clear | glob_clear;

  always @* begin
    wstb_nxt  = 1'b0;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    if (wr_clr) begin
      waddr_nxt = {AW{1'b0}};
      wdata_nxt = {DW{1'b0}};
    end else if (wr_take) begin
      wstb_nxt  = wr_strobe;
      waddr_nxt = wr_addr;
      wdata_nxt = wr_data;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wstb_r  <= 1'b0;
      waddr_r <= {AW{1'b0}};
      wdata_r <= {DW{1'b0}};
    end else begin
      wstb_r  <= wstb_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // array write one cycle after capture; contents survive clears to save reset fan-out
  always @(posedge ref_clk) begin
    if (wstb_r) begin
      mem[waddr_r] <= wdata_r;
    end
  end

  // read group: touched only by the read clock, its gate, its clear and the global clear
  assign rd_clr = rd_clear | glob_clear;

  always @* begin
    fetch_nxt = fetch_r;
    raddr_nxt = raddr_r;
    if (rd_clr) begin
      fetch_nxt = 1'b0;
      raddr_nxt = {AW{1'b0}};
    end else if (rd_take) begin
      fetch_nxt = fetch_strobe;
      raddr_nxt = rd_addr;
    end
  end

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_r <= 1'b0;
      raddr_r <= {AW{1'b0}};
    end else begin
      fetch_r <= fetch_nxt;
      raddr_r <= raddr_nxt;
    end
  end

  // a word never written reads back unknown, since the array has no reset
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= {DW{1'b0}};
    end else if (rd_clr) begin
      rd_data_r <= {DW{1'b0}};
    end else if (rd_take && fetch_r) begin
      rd_data_r <= mem[raddr_r];
    end
  end

  // shared clear lines for macrocells
  assign shared_src       = pt_glob_clr | pt_loc_clr;
  assign shared_clr       = shared_src ^ pt_clr_inv;
  assign shared_clear_one = shared_clr[0];
  assign shared_clear_two = shared_clr[1];

  genvar g;
  generate
    for (g = 0; g < NMC; g = g + 1) begin : g_mc
      reg  [`EAB_SET_BITS-1:0] sets;
      reg                      or_v;
      reg                      clr_v;
      wire [`EAB_SEL_W-1:0]    sel;
      integer                  k;
      always @* begin
        sets = pt_exp_sets[g*`EAB_SET_BITS +: `EAB_SET_BITS];
        or_v = |pt_terms[g*`EAB_OWN_TERMS +: `EAB_OWN_TERMS];
        // each set is the two terms of one lower neighbour; low cells have fewer lenders
        for (k = 1; k <= `EAB_MAX_SETS; k = k + 1) begin
          if (k <= sets && k <= g) begin
            or_v = or_v | (|pt_terms[(g-k)*`EAB_OWN_TERMS +: `EAB_OWN_TERMS]);
          end
        end
      end
      assign sel = pt_clr_sel[g*`EAB_SEL_W +: `EAB_SEL_W];
      // the spare select code is treated as no clear
      always @* begin
        case (sel)
          `EAB_SEL_ONE: clr_v = shared_clear_one;
          `EAB_SEL_TWO: clr_v = shared_clear_two;
          default:      clr_v = 1'b0;
        endcase
      end
      assign mc_or[g]  = or_v;
      assign mc_clr[g] = clr_v;
      assign mc_nxt[g] = mc_clr[g] ? 1'b0 : mc_or[g];
    end
  endgenerate

  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mc_out_r <= {NMC{1'b0}};
    end else begin
      mc_out_r <= mc_nxt;
    end
  end
endmodule // eab_block
`default_nettype wire

//--- tb/eab_block_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module eab_chk #(parameter AW = 4, DW = 8, NMC = 16) (
  input wire ref_clk, rst_b, glob_clear, rd_clear, clock_gate_two,
  input wire [1:0] pt_glob_clr, pt_loc_clr, pt_clr_inv,
  input wire [2*NMC-1:0] pt_clr_sel, pt_terms,
  input wire [4*NMC-1:0] pt_exp_sets,
  input wire [DW-1:0] rd_data_r,
  input wire [NMC-1:0] mc_out_r);
  wire [1:0] ln = (pt_glob_clr | pt_loc_clr) ^ pt_clr_inv;
  wire [1:0] s0 = pt_clr_sel[1:0];
  wire [1:0] s1 = pt_clr_sel[3:2];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // three idle samples cover an event still in flight
  sequence s_rd_idle; !clock_gate_two [*3] ##0 !(rd_clear | glob_clear); endsequence
  a_clr_line_one: assert property (s0 == 2'h1 && ln[0] |=> !mc_out_r[0]) else $error("line one");
  a_clr_line_two: assert property (s0 == 2'h2 && ln[1] |=> !mc_out_r[0]) else $error("line two");
  a_clr_none_or: assert property (s0 == 2'h0 || s0 == 2'h3 |=> mc_out_r[0] == $past(|pt_terms[1:0]))
    else $error("own terms");
  a_lend_none: assert property (s1 == 2'h0 && pt_exp_sets[7:4] == 4'h0 |=> mc_out_r[1] == $past(|pt_terms[3:2]))
    else $error("no sets");
  a_lend_one_set: assert property (s1 == 2'h0 && pt_exp_sets[7:4] != 4'h0 |=> mc_out_r[1] == $past(|pt_terms[3:0]))
    else $error("lent set");
  a_glob_rd_zero: assert property (glob_clear |=> rd_data_r == '0) else $error("global clear");
  a_loc_rd_zero: assert property (rd_clear |=> rd_data_r == '0) else $error("read clear");
  a_gate_rd_hold: assert property (s_rd_idle |=> $stable(rd_data_r)) else $error("gated read");
endmodule // eab_chk
`default_nettype wire

//--- tb/eab_fab.sv
`timescale 1ns/1ps
`default_nettype none
module eab_fab (input wire ref_clk, run, slow, output logic wr_clk, rd_clk);
  logic ph_r = 1'b0;
  initial {wr_clk, rd_clk} = 2'h0;
  // clocks stand still while idle; slow halves the read rate
  always @(posedge ref_clk) begin
    #1;
    ph_r = ~ph_r;
    if (run) wr_clk = ~wr_clk;
    if (run && (!slow || ph_r)) rd_clk = ~rd_clk;
  end
endmodule // eab_fab
`default_nettype wire

//--- tb/tb_eab_block.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eab_block;
  logic ref_clk = 0, rst_b = 0, glob_clear = 0, clock_gate_one = 0, wr_clear = 0, wr_strobe = 0;
  logic clock_gate_two = 0, rd_clear = 0, fetch_strobe = 0, run = 0, slow = 0, wr_clk, rd_clk;
  logic [3:0] wr_addr = '0, rd_addr = '0;
  logic [7:0] wr_data = '0, rd_data_r;
  logic [1:0] pt_glob_clr = '0, pt_loc_clr = '0, pt_clr_inv = '0;
  logic [31:0] pt_clr_sel = '0, pt_terms = '0;
  logic [63:0] pt_exp_sets = '0;
  logic [15:0] mc_out_r;
  int errors = 0, checks_done = 0;
  always #50 ref_clk = ~ref_clk;
  eab_block dut (.*);
  eab_fab fab (.*);
  task chk(input logic [15:0] s, e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("Error %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task cyc(input int n); repeat (n) @(posedge ref_clk); #1; endtask
  task wr(input logic [3:0] a, input logic [7:0] d, input logic g);
    {clock_gate_one, wr_strobe, wr_addr, wr_data} = {g, 1'b1, a, d};
    cyc(4);
    {clock_gate_one, wr_strobe} = 2'h0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e);
    {clock_gate_two, fetch_strobe, rd_addr} = {2'h3, a};
    cyc(10);
    chk(rd_data_r, e);
  endtask
  task t_mem;
    run = 1;
    wr(4'h3, 8'hA5, 1); rd(4'h3, 8'hA5);
    wr(4'h3, 8'h5A, 0); rd(4'h3, 8'hA5);
    wr(4'hF, 8'h3C, 1); slow = 1; rd(4'hF, 8'h3C);
    clock_gate_two = 0; cyc(4); chk(rd_data_r, 8'h3C);
    wr_clear = 1; wr(4'hF, 8'hC3, 1); wr_clear = 0; chk(rd_data_r, 8'h3C);
    rd_clear = 1; cyc(2); rd_clear = 0; chk(rd_data_r, 8'h00);
    rd(4'hF, 8'h3C);
    rd(4'h3, 8'hA5); glob_clear = 1; cyc(2); glob_clear = 0; chk(rd_data_r, 8'h00);
    run = 0;
    $display("memory test done");
  endtask
  task t_pt;
    logic [1:0] e;
    pt_terms = 32'h1;
    for (int i = 0; i < 128; i++) begin
      {pt_clr_inv, pt_loc_clr, pt_glob_clr} = i[5:0];
      pt_clr_sel[1:0] = i[6] ? 2'h2 : 2'h1;
      e = (pt_glob_clr | pt_loc_clr) ^ pt_clr_inv;
      cyc(2); chk(mc_out_r[0], !e[i[6]]);
    end
    pt_clr_sel[1:0] = 2'h3; cyc(2); chk(mc_out_r, 16'h0001);
    pt_exp_sets = {4'hF, 60'h0}; cyc(2); chk(mc_out_r, 16'h8001);
    pt_exp_sets = {4'hE, 52'h0, 4'h1, 4'h0}; cyc(2); chk(mc_out_r, 16'h0003);
    $display("product term test done");
  endtask
  task conclude;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin cyc(5); rst_b = 1; cyc(3); t_mem; t_pt; conclude; end
  initial begin #100000; errors++; conclude; end
endmodule // tb_eab_block
bind eab_block eab_chk #(.AW(AW), .DW(DW), .NMC(NMC)) u_chk (.*);
`default_nettype wire
